// [src/dpc_top.sv]
// data path control register with forward channel loading and pixel path
//
// Notes on behaviour
// - With the lock bit 7 set, forward channel loads are ignored and local values kept.
// - Bits 6..0 follow the values sent by the remote serializer unless bit 7 is set.
// - Bit 6 set sends pixel data on the pins whatever the data enable does.
// - While bit 6 is set no packetised audio is delivered.
// - Bit 5 set drives data enable active low, clear drives it active high.
// - Bit 4 set keeps packetised aux and audio data off the video pins.
// - Bit 3 set takes the second audio enable from bit 0, clear from the mode strap pin.
// - Bit 2 set selects 18-bit video, clear selects 24-bit video.
// - Bit 1 set carries audio in forward channel frames, clear in data islands.
// - Second audio channel enable drives that channel on the blue bit 1 pin.
`timescale 1ns/10ps
module dpc_top #(
	parameter int unsigned PIX_W = dpc_pkg::PIX_W
) (
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic                       host_wr,
	input  wire logic                       host_rd,
	input  wire logic [dpc_pkg::ADDR_W-1:0] host_addr,
	input  wire logic [dpc_pkg::DATA_W-1:0] host_wdata,
	output logic      [dpc_pkg::DATA_W-1:0] host_rdata,
	output logic                            host_rvalid,
	input  wire logic                       fc_load,
	input  wire logic [dpc_pkg::FC_W-1:0]   fc_bits,
	input  wire logic                       mode_sel_pin,
	input  wire logic [PIX_W-1:0]           pix_in,
	input  wire logic                       data_enable_in,
	input  wire logic                       aux_valid,
	input  wire logic [PIX_W-1:0]           aux_data,
	input  wire logic                       chb_in,
	output logic      [PIX_W-1:0]           rgb_out,
	output logic                            data_enable_out,
	output logic                            audio_valid,
	output logic                            audio_via_fc,
	output logic                            chb_active
);
	// ****************************************
	// declarations
	// ****************************************
	logic [dpc_pkg::DATA_W-1:0]      ctrl_q;
	logic [dpc_pkg::SYNC_STAGES-1:0] strap_sync_q;
	logic                            strap_q;
	logic                            wr_hit;
	logic                            rd_hit;
	logic                            fc_take;
	logic                            chb_en;

	dpc_cfg_if cfg ();

	// ****************************************
	// host port decode
	// ****************************************
	// only one register lives here, other offsets read as zero
	assign wr_hit  = host_wr && (host_addr == dpc_pkg::ADDR_DATA_PATH);
	assign rd_hit  = host_rd && (host_addr == dpc_pkg::ADDR_DATA_PATH);
	assign fc_take = fc_load && !ctrl_q[dpc_pkg::BIT_LOCK_LOCAL];

	// ****************************************
	// data path control register
	// ****************************************
	// a host write in the same cycle as a remote load wins, so local intent is kept
	// remote load of bits 6..0
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= dpc_pkg::DATA_PATH_RESET;
		end else if (wr_hit) begin
			ctrl_q <= host_wdata;
		end else if (fc_take) begin
			ctrl_q[dpc_pkg::FC_W-1:0] <= fc_bits;
		end
	end

	// ****************************************
	// host read
	// ****************************************
	// read of live value
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			host_rdata  <= '0;
			host_rvalid <= 1'b0;
		end else begin
			host_rvalid <= host_rd;
			if (rd_hit) begin
				host_rdata <= ctrl_q;
			end else if (host_rd) begin
				host_rdata <= dpc_pkg::UNMAPPED_READ;
			end
		end
	end

	// ****************************************
	// mode strap synchroniser
	// ****************************************
	// the pin is asynchronous; stage 0 feeds only stage 1
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			strap_sync_q <= '0;
		end else begin
			strap_sync_q <= {strap_sync_q[dpc_pkg::SYNC_STAGES-2:0], mode_sel_pin};
		end
	end

	// a change counts only once the last two stages agree
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			strap_q <= dpc_pkg::MODE_STRAP_RESET;
		end else if (strap_sync_q[2] == strap_sync_q[1]) begin
			strap_q <= strap_sync_q[2];
		end
	end

	// ****************************************
	// resolved settings for the pixel path
	// ****************************************
	// second channel source select
	assign chb_en = ctrl_q[dpc_pkg::BIT_CHB_FROM_REG] ? ctrl_q[dpc_pkg::BIT_CHB_ENABLE] : strap_q;

	assign cfg.passthrough    = ctrl_q[dpc_pkg::BIT_PASSTHROUGH];
	assign cfg.enable_low     = ctrl_q[dpc_pkg::BIT_DATA_ENABLE_LOW];
	assign cfg.no_aux_on_pins = ctrl_q[dpc_pkg::BIT_NO_AUX_ON_PINS];
	assign cfg.chb_enable     = chb_en;
	assign cfg.video_18       = ctrl_q[dpc_pkg::BIT_VIDEO_18];
	assign cfg.audio_via_fc   = ctrl_q[dpc_pkg::BIT_AUDIO_VIA_FC];

	// pixel path, all its outputs leave from flip-flops
	dpc_path #(
		.PIX_W (PIX_W)
	) u_path (
		.clk             (clk),
		.rst             (rst),
		.cfg             (cfg),
		.pix_in          (pix_in),
		.data_enable_in  (data_enable_in),
		.aux_valid       (aux_valid),
		.aux_data        (aux_data),
		.chb_in          (chb_in),
		.rgb_out         (rgb_out),
		.data_enable_out (data_enable_out),
		.audio_valid     (audio_valid),
		.audio_via_fc    (audio_via_fc),
		.chb_active      (chb_active)
	);

	// ****************************************
	// assertions
	// ****************************************
	// lock holds register
	a_lock_blocks_load: assert property (
		@(posedge clk) disable iff (rst)
		(fc_load && !wr_hit && ctrl_q[dpc_pkg::BIT_LOCK_LOCAL]) |=> $stable(ctrl_q)
	) else $error("remote load changed a locked register");

	a_fc_load_applies: assert property (
		@(posedge clk) disable iff (rst)
		(fc_load && !wr_hit && !ctrl_q[dpc_pkg::BIT_LOCK_LOCAL]) |=>
			(ctrl_q[dpc_pkg::FC_W-1:0] == $past(fc_bits)) &&
			(ctrl_q[dpc_pkg::BIT_LOCK_LOCAL] == 1'b0)
	) else $error("remote load not applied to bits 6..0");

	a_bypass_pixels: assert property (
		@(posedge clk) disable iff (rst)
		(cfg.passthrough && !cfg.video_18 && !chb_en && !data_enable_in) |=>
			(rgb_out == $past(pix_in))
	) else $error("pixels not passed with data enable low in bypass");

	a_bypass_no_audio: assert property (
		@(posedge clk) disable iff (rst)
		cfg.passthrough |=> !audio_valid
	) else $error("audio delivered while bypass set");

	a_enable_polarity: assert property (
		@(posedge clk) disable iff (rst)
		##1 (data_enable_out ==
			($past(data_enable_in) ^ $past(ctrl_q[dpc_pkg::BIT_DATA_ENABLE_LOW])))
	) else $error("data enable polarity wrong");

	a_aux_off_pins: assert property (
		@(posedge clk) disable iff (rst)
		(!data_enable_in && aux_valid && cfg.no_aux_on_pins && !cfg.passthrough) |=>
			(rgb_out[PIX_W-1:2] == '0) && !rgb_out[0]
	) else $error("packet data reached video pins");

	a_chb_source: assert property (
		@(posedge clk) disable iff (rst)
		##1 (chb_active == ($past(ctrl_q[dpc_pkg::BIT_CHB_FROM_REG]) ?
			$past(ctrl_q[dpc_pkg::BIT_CHB_ENABLE]) : $past(strap_q)))
	) else $error("second channel enable from wrong source");

	a_video18_trim: assert property (
		@(posedge clk) disable iff (rst)
		cfg.video_18 |=> (rgb_out[17:16] == 2'b00) && (rgb_out[9:8] == 2'b00)
	) else $error("colour lsbs not cleared in 18-bit mode");

	a_audio_transport: assert property (
		@(posedge clk) disable iff (rst)
		##1 (audio_via_fc == $past(ctrl_q[dpc_pkg::BIT_AUDIO_VIA_FC]))
	) else $error("audio transport not following register");

	a_chb_on_blue1: assert property (
		@(posedge clk) disable iff (rst)
		chb_en |=> (rgb_out[dpc_pkg::BLUE_BIT1] == $past(chb_in)) && chb_active
	) else $error("second channel missing on blue bit 1");

	a_read_value: assert property (
		@(posedge clk) disable iff (rst)
		rd_hit |=> host_rvalid && (host_rdata == $past(ctrl_q))
	) else $error("read did not return register value");

	a_unmapped_read: assert property (
		@(posedge clk) disable iff (rst)
		(host_rd && !rd_hit) |=> host_rvalid && (host_rdata == dpc_pkg::UNMAPPED_READ)
	) else $error("unmapped read did not return the idle value");

	a_rvalid_pulse: assert property (
		@(posedge clk) disable iff (rst)
		!host_rd |=> !host_rvalid
	) else $error("read valid without a read");

	a_write_lands: assert property (
		@(posedge clk) disable iff (rst)
		wr_hit |=> (ctrl_q == $past(host_wdata))
	) else $error("host write not held in the register");

	a_lock_bit_local: assert property (
		@(posedge clk) disable iff (rst)
		!wr_hit |=> $stable(ctrl_q[dpc_pkg::BIT_LOCK_LOCAL])
	) else $error("lock bit changed without a host write");

	// blue bit 1 is left out of the blank check, the second channel may own it
	// framed idle is blank
	a_framed_blank: assert property (
		@(posedge clk) disable iff (rst)
		(!cfg.passthrough && !data_enable_in && !aux_valid) |=>
			(rgb_out[PIX_W-1:2] == '0) && !rgb_out[0]
	) else $error("pins not blank outside the frame");

	a_audio_follows: assert property (
		@(posedge clk) disable iff (rst)
		!cfg.passthrough |=> (audio_valid == $past(aux_valid))
	) else $error("audio not delivered in framed operation");

	a_aux_on_pins: assert property (
		@(posedge clk) disable iff (rst)
		(!data_enable_in && aux_valid && !cfg.no_aux_on_pins && !cfg.passthrough &&
			!cfg.video_18 && !chb_en) |=> (rgb_out == $past(aux_data))
	) else $error("packet data missing from video pins");

	a_full_width: assert property (
		@(posedge clk) disable iff (rst)
		(!cfg.video_18 && data_enable_in && !chb_en) |=> (rgb_out == $past(pix_in))
	) else $error("pixels altered in 24-bit mode");

	a_strap_agree: assert property (
		@(posedge clk) disable iff (rst)
		(strap_sync_q[2] != strap_sync_q[1]) |=> $stable(strap_q)
	) else $error("strap value taken before two stages agreed");

	// ****************************************
	// covers
	// ****************************************
	c_locked_load: cover property (
		@(posedge clk) disable iff (rst)
		fc_load && ctrl_q[dpc_pkg::BIT_LOCK_LOCAL]
	);

	c_remote_load: cover property (
		@(posedge clk) disable iff (rst)
		fc_take ##2 rd_hit
	);

	c_bypass_idle: cover property (
		@(posedge clk) disable iff (rst)
		cfg.passthrough && !data_enable_in && aux_valid
	);

	c_strap_channel: cover property (
		@(posedge clk) disable iff (rst)
		!ctrl_q[dpc_pkg::BIT_CHB_FROM_REG] && strap_q
	);

	c_aux_on_pins: cover property (
		@(posedge clk) disable iff (rst)
		!data_enable_in && aux_valid && !cfg.no_aux_on_pins && !cfg.passthrough
	);

endmodule : dpc_top

// [common/dpc_pkg.sv]
// shared constants for the data path control register block
package dpc_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam int unsigned ADDR_W                = 8;
	localparam int unsigned DATA_W                = 8;
	localparam int unsigned FC_W                  = 7;
	localparam logic [7:0]  ADDR_DATA_PATH        = 8'h22;
	localparam logic [7:0]  DATA_PATH_RESET       = 8'h00;
	localparam logic [7:0]  UNMAPPED_READ         = 8'h00;

	// ****************************************
	// field positions of the data path control register
	// ****************************************
	localparam int unsigned BIT_LOCK_LOCAL        = 7;
	localparam int unsigned BIT_PASSTHROUGH       = 6;
	localparam int unsigned BIT_DATA_ENABLE_LOW   = 5;
	localparam int unsigned BIT_NO_AUX_ON_PINS    = 4;
	localparam int unsigned BIT_CHB_FROM_REG      = 3;
	localparam int unsigned BIT_VIDEO_18          = 2;
	localparam int unsigned BIT_AUDIO_VIA_FC      = 1;
	localparam int unsigned BIT_CHB_ENABLE        = 0;

	// ****************************************
	// pixel layout and pin synchroniser
	// ****************************************
	localparam int unsigned PIX_W                 = 24;
	localparam int unsigned TRIM_BITS             = 2;
	localparam int unsigned BLUE_BIT1             = 1;
	localparam int unsigned SYNC_STAGES           = 3;
	localparam logic        MODE_STRAP_RESET      = 1'b0;

endpackage : dpc_pkg

// [common/dpc_cfg_if.sv]
// resolved configuration passed from the register to the pixel path
`timescale 1ns/10ps
interface dpc_cfg_if;
	logic passthrough;     // pixels sent regardless of data enable
	logic enable_low;      // output data enable polarity
	logic no_aux_on_pins;  // keep packet data off the video pins
	logic chb_enable;      // second audio channel, source already resolved
	logic video_18;        // 18-bit mode trims colour lsbs
	logic audio_via_fc;    // audio transport choice

	modport ctrl (
		output passthrough,
		output enable_low,
		output no_aux_on_pins,
		output chb_enable,
		output video_18,
		output audio_via_fc
	);

	modport path (
		input  passthrough,
		input  enable_low,
		input  no_aux_on_pins,
		input  chb_enable,
		input  video_18,
		input  audio_via_fc
	);
endinterface : dpc_cfg_if

// [src/dpc_path.sv]
// recovered pixel path steered by the data path control settings
`timescale 1ns/10ps
module dpc_path #(
	parameter int unsigned PIX_W = dpc_pkg::PIX_W
) (
	input  wire logic             clk,
	input  wire logic             rst,
	dpc_cfg_if.path               cfg,
	input  wire logic [PIX_W-1:0] pix_in,
	input  wire logic             data_enable_in,
	input  wire logic             aux_valid,
	input  wire logic [PIX_W-1:0] aux_data,
	input  wire logic             chb_in,
	output logic      [PIX_W-1:0] rgb_out,
	output logic                  data_enable_out,
	output logic                  audio_valid,
	output logic                  audio_via_fc,
	output logic                  chb_active
);
	localparam int unsigned CH_W = PIX_W / 3;

	// the trim and blue lane logic need three equal colour lanes
	generate
		if ((PIX_W % 3) != 0 || CH_W <= dpc_pkg::TRIM_BITS) begin : g_bad_width
			$error("dpc_path: PIX_W must be three equal lanes wider than the trim");
		end
	endgenerate

	logic [PIX_W-1:0] sel_pix;
	logic [PIX_W-1:0] trim_pix;
	logic [PIX_W-1:0] pin_pix;

	// ****************************************
	// pin data selection
	// ****************************************
	// framing bypass
	always_comb begin
		sel_pix = '0;
		if (cfg.passthrough || data_enable_in) begin
			sel_pix = pix_in;
		end else if (aux_valid && !cfg.no_aux_on_pins) begin
			sel_pix = aux_data;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_lane
			assign trim_pix[g*CH_W +: CH_W] = cfg.video_18 ?
				{sel_pix[g*CH_W + dpc_pkg::TRIM_BITS +: CH_W - dpc_pkg::TRIM_BITS],
				 {dpc_pkg::TRIM_BITS{1'b0}}} :
				sel_pix[g*CH_W +: CH_W];
		end
	endgenerate

	// second audio channel on blue bit 1
	always_comb begin
		pin_pix = trim_pix;
		if (cfg.chb_enable) begin
			pin_pix[dpc_pkg::BLUE_BIT1] = chb_in;
		end
	end

	// ****************************************
	// registered outputs
	// ****************************************
	// one cycle of latency from pins and settings alike
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rgb_out <= '0;
		end else begin
			rgb_out <= pin_pix;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			data_enable_out <= 1'b0;
		end else begin
			data_enable_out <= data_enable_in ^ cfg.enable_low;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			audio_valid  <= 1'b0;
			audio_via_fc <= 1'b0;
			chb_active   <= 1'b0;
		end else begin
			audio_valid  <= aux_valid && !cfg.passthrough;
			audio_via_fc <= cfg.audio_via_fc;
			chb_active   <= cfg.chb_enable;
		end
	end

endmodule : dpc_path

// [dv/dpc_fc_model.sv]
// remote serializer model driving forward channel loads
`timescale 1ns/10ps
module dpc_fc_model (
	input  wire logic       clk,
	output logic            fc_load,
	output logic      [6:0] fc_bits
);
	// idle lines start low
	initial begin
		fc_load = 1'b0;
		fc_bits = 7'h00;
	end

	// ****************************************
	// one load per call
	// ****************************************
	// one-cycle load pulse
	task automatic send(input logic [6:0] v);
		@(negedge clk);
		fc_load = 1'b1;
		fc_bits = v;
		@(negedge clk);
		fc_load = 1'b0;
		// stale bits flipped so a late sample cannot pass by luck
		fc_bits = ~v;
	endtask : send
endmodule : dpc_fc_model

// [dv/tb.sv]
// register and pixel path testbench for the data path control block
`timescale 1ns/10ps
module tb;
	logic        clk, rst, host_wr, host_rd, host_rvalid, fc_load, mode_sel_pin;
	logic        data_enable_in, data_enable_out, aux_valid, chb_in;
	logic        audio_valid, audio_via_fc, chb_active;
	logic [7:0]  host_addr, host_wdata, host_rdata;
	logic [6:0]  fc_bits;
	logic [23:0] pix_in, aux_data, rgb_out;
	int          err_count   = 0;
	int          checks_done = 0;

	// ****************************************
	// clock, design and remote model
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	dpc_top #(.PIX_W(24)) uut (.clk(clk), .rst(rst), .host_wr(host_wr), .host_rd(host_rd),
		.host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
		.host_rvalid(host_rvalid), .fc_load(fc_load), .fc_bits(fc_bits),
		.mode_sel_pin(mode_sel_pin), .pix_in(pix_in), .data_enable_in(data_enable_in),
		.aux_valid(aux_valid), .aux_data(aux_data), .chb_in(chb_in), .rgb_out(rgb_out),
		.data_enable_out(data_enable_out), .audio_valid(audio_valid),
		.audio_via_fc(audio_via_fc), .chb_active(chb_active));

	dpc_fc_model fc (.clk(clk), .fc_load(fc_load), .fc_bits(fc_bits));

	// ****************************************
	// access tasks
	// ****************************************
	task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		host_wr    = 1'b1;
		host_addr  = a;
		host_wdata = d;
		@(negedge clk);
		host_wr = 1'b0;
	endtask : wr

	// rvalid stands one cycle, so it is looked at in that cycle
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		host_rd   = 1'b1;
		host_addr = a;
		@(negedge clk);
		host_rd = 1'b0;
		chk("host_rvalid", {23'h0, host_rvalid}, 24'h00_0001);
		chk("host_rdata", {16'h0, host_rdata}, {16'h0, exp});
	endtask : rd

	// one pixel beat; outputs are settled by the next falling edge
	task automatic px(input logic [23:0] p, input logic en, input logic av, input logic cb);
		@(negedge clk);
		pix_in         = p;
		data_enable_in = en;
		aux_valid      = av;
		chb_in         = cb;
		@(negedge clk);
	endtask : px

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude

	// hang guard well above the run length
	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		conclude();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		rst            = 1'b1;
		host_wr        = 1'b0;
		host_rd        = 1'b0;
		host_addr      = 8'h00;
		host_wdata     = 8'h00;
		mode_sel_pin   = 1'b0;
		pix_in         = 24'h00_0000;
		data_enable_in = 1'b0;
		aux_valid      = 1'b0;
		aux_data       = 24'hAB_CDEF;
		chb_in         = 1'b0;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		rd(dpc_pkg::ADDR_DATA_PATH, dpc_pkg::DATA_PATH_RESET);
		rd(8'h23, dpc_pkg::UNMAPPED_READ);
		wr(8'h21, 8'hFF);
		rd(dpc_pkg::ADDR_DATA_PATH, 8'h00);
		$display("test register access done");
		// the model never asks for pass-through with the matching pair
		fc.send(7'h15);
		rd(dpc_pkg::ADDR_DATA_PATH, 8'h15);
		wr(dpc_pkg::ADDR_DATA_PATH, 8'h80);
		fc.send(7'h2A);
		rd(dpc_pkg::ADDR_DATA_PATH, 8'h80);
		wr(dpc_pkg::ADDR_DATA_PATH, 8'h00);
		fc.send(7'h2A);
		rd(dpc_pkg::ADDR_DATA_PATH, 8'h2A);
		$display("test remote loading done");
		wr(dpc_pkg::ADDR_DATA_PATH, 8'h40);
		px(24'h12_3456, 1'b0, 1'b1, 1'b0);
		chk("rgb_out", rgb_out, 24'h12_3456);
		chk("audio_valid", {23'h0, audio_valid}, 24'h00_0000);
		wr(dpc_pkg::ADDR_DATA_PATH, 8'h00);
		px(24'h12_3456, 1'b0, 1'b1, 1'b0);
		chk("rgb_out", rgb_out, 24'hAB_CDEF);
		chk("audio_valid", {23'h0, audio_valid}, 24'h00_0001);
		chk("data_enable_out", {23'h0, data_enable_out}, 24'h00_0000);
		wr(dpc_pkg::ADDR_DATA_PATH, 8'h10);
		px(24'h12_3456, 1'b0, 1'b1, 1'b0);
		chk("rgb_out", rgb_out, 24'h00_0000);
		$display("test pass-through and aux done");
		wr(dpc_pkg::ADDR_DATA_PATH, 8'h20);
		px(24'h12_3456, 1'b1, 1'b0, 1'b0);
		chk("data_enable_out", {23'h0, data_enable_out}, 24'h00_0000);
		px(24'h12_3456, 1'b0, 1'b0, 1'b0);
		chk("data_enable_out", {23'h0, data_enable_out}, 24'h00_0001);
		wr(dpc_pkg::ADDR_DATA_PATH, 8'h04);
		px(24'hFF_FFFF, 1'b1, 1'b0, 1'b0);
		chk("rgb_out", rgb_out, 24'hFC_FCFC);
		chk("audio_via_fc", {23'h0, audio_via_fc}, 24'h00_0000);
		wr(dpc_pkg::ADDR_DATA_PATH, 8'h02);
		px(24'hFF_FFFF, 1'b1, 1'b0, 1'b0);
		chk("rgb_out", rgb_out, 24'hFF_FFFF);
		chk("audio_via_fc", {23'h0, audio_via_fc}, 24'h00_0001);
		$display("test polarity width transport done");
		mode_sel_pin = 1'b1;
		wr(dpc_pkg::ADDR_DATA_PATH, 8'h09);
		px(24'h00_0000, 1'b1, 1'b0, 1'b1);
		chk("rgb_out", rgb_out, 24'h00_0002);
		chk("chb_active", {23'h0, chb_active}, 24'h00_0001);
		wr(dpc_pkg::ADDR_DATA_PATH, 8'h08);
		px(24'h00_0000, 1'b1, 1'b0, 1'b1);
		chk("rgb_out", rgb_out, 24'h00_0000);
		chk("chb_active", {23'h0, chb_active}, 24'h00_0000);
		// strap path settles within a handful of edges
		wr(dpc_pkg::ADDR_DATA_PATH, 8'h00);
		repeat (6) @(negedge clk);
		px(24'h00_0000, 1'b1, 1'b0, 1'b1);
		chk("chb_active", {23'h0, chb_active}, 24'h00_0001);
		mode_sel_pin = 1'b0;
		repeat (6) @(negedge clk);
		px(24'h00_0000, 1'b1, 1'b0, 1'b1);
		chk("chb_active", {23'h0, chb_active}, 24'h00_0000);
		$display("test second channel done");
		conclude();
	end
endmodule : tb
